// ### verilog/tpr_pkg.sv
// Purpose: Shared constants and types for the training pattern readout block
// Assumes: One command per ref_clk cycle, pattern burst of eight unit intervals
// Notes: Offsets here are bit positions of the 13-bit training mode register
package tpr_pkg;

    // ----------------------------------------------------------------
    // Training mode register layout
    // ----------------------------------------------------------------
    localparam int TMR_W = 13;
    localparam logic [12:0] TMR_RST = 13'h0000;
    localparam int TMR_PAGE_LSB = 0;
    localparam int TMR_MODE_BIT = 2;
    localparam int TMR_FMT_LSB = 11;

    localparam logic [1:0] FMT_SERIAL = 2'h0;
    localparam logic [1:0] FMT_PARALLEL = 2'h1;
    localparam logic [1:0] FMT_STAGGER = 2'h2;

    // ----------------------------------------------------------------
    // Pattern storage
    // ----------------------------------------------------------------
    localparam int LOC_W = 8;
    localparam int LOC_N = 4;
    localparam int RO_PAGES = 3;
    localparam int NIBBLE = 4;
    localparam logic [7:0] LOC0_RST = 8'h55;
    localparam logic [7:0] LOC1_RST = 8'h33;
    localparam logic [7:0] LOC2_RST = 8'h0f;
    localparam logic [7:0] LOC3_RST = 8'h00;

    // ----------------------------------------------------------------
    // Burst timing
    // ----------------------------------------------------------------
    localparam int BURST_UI = 8;
    localparam logic [2:0] LAST_UI = 3'h7;

    typedef enum logic [1:0] {
        TPR_OP_NOP,
        TPR_OP_MODE_SET,
        TPR_OP_READ,
        TPR_OP_WRITE
    } tpr_op_e;

    typedef enum logic {
        TPR_TX_IDLE,
        TPR_TX_SEND
    } tpr_tx_e;

endpackage

// ### verilog/tpr_link_if.sv
// Purpose: Carries one formatted burst from the command domain to the link domain
// Assumes: word is held stable from a req_tgl change until ack_tgl answers
// Notes: Toggle handshake, both toggles are synchronised by the receiver
`timescale 1ns/1ps
interface tpr_link_if #(parameter int DQ_W = 8);
    logic [8*DQ_W-1:0] word;
    logic req_tgl;
    logic ack_tgl;
    modport core (output word, output req_tgl, input ack_tgl);
    modport link (input word, input req_tgl, output ack_tgl);
endinterface

// ### verilog/tpr_burst_tx.sv
// Purpose: Link-side burst sender with one-deep next slot for gapless streams
// Assumes: dev_clk runs freely, one unit interval per dev_clk cycle
// Notes: Reset and clock enable reach this domain through two-flop synchronisers
`timescale 1ns/1ps
module tpr_burst_tx #(
    parameter int DQ_W = 8
) (
    input wire logic dev_clk,
    input wire logic srst,
    input wire logic ce,
    tpr_link_if.link lk,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe,
    output logic dqs_t_o,
    output logic dqs_c_o,
    output logic dqs_oe
);
    logic rst_s1, rst_s2, ce_s1, ce_s2, req_s1, req_s2;
    logic seen_r, ack_r, nxt_v_r, dqs_r;
    logic [8*DQ_W-1:0] cur_r, nxt_r;
    logic [2:0] ui_r;
    tpr_pkg::tpr_tx_e st_r;
    logic capture, load, last_ui;

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge dev_clk) begin
        rst_s1 <= srst;
        rst_s2 <= rst_s1;
        ce_s1 <= ce;
        ce_s2 <= ce_s1;
    end

    always_ff @(posedge dev_clk) begin
        if (rst_s2) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else if (ce_s2) begin
            req_s1 <= lk.req_tgl;
            req_s2 <= req_s1;
        end
    end

    // ----------------------------------------------------------------
    // Next slot: a new burst is only taken once the slot is free,
    // so the ack is held back and the core stalls behind it
    // ----------------------------------------------------------------
    assign last_ui = (ui_r == tpr_pkg::LAST_UI);
    assign capture = (req_s2 != seen_r) && !nxt_v_r;
    assign load = nxt_v_r && ((st_r == tpr_pkg::TPR_TX_IDLE) || last_ui);

    always_ff @(posedge dev_clk) begin
        if (rst_s2) begin
            seen_r <= 1'b0;
            ack_r <= 1'b0;
            nxt_v_r <= 1'b0;
            nxt_r <= '0;
        end else if (ce_s2) begin
            if (capture) begin
                seen_r <= req_s2;
                ack_r <= ~ack_r;
                nxt_r <= lk.word;
                nxt_v_r <= 1'b1;
            end else if (load) begin
                nxt_v_r <= 1'b0;
            end
        end
    end
    assign lk.ack_tgl = ack_r;

    // ----------------------------------------------------------------
    // Shifter: next burst follows the last UI directly
    // ----------------------------------------------------------------
    always_ff @(posedge dev_clk) begin
        if (rst_s2) begin
            st_r <= tpr_pkg::TPR_TX_IDLE;
            cur_r <= '0;
            ui_r <= 3'h0;
            dqs_r <= 1'b0;
        end else if (ce_s2) begin
            case (st_r)
                tpr_pkg::TPR_TX_IDLE: begin
                    if (load) begin
                        st_r <= tpr_pkg::TPR_TX_SEND;
                        cur_r <= nxt_r;
                        ui_r <= 3'h0;
                        dqs_r <= 1'b1;
                    end
                end
                tpr_pkg::TPR_TX_SEND: begin
                    if (load) begin
                        cur_r <= nxt_r;
                        ui_r <= 3'h0;
                        dqs_r <= 1'b1;
                    end else if (last_ui) begin
                        st_r <= tpr_pkg::TPR_TX_IDLE;
                        dqs_r <= 1'b0;
                    end else begin
                        cur_r <= {cur_r[8*DQ_W-DQ_W-1:0], {DQ_W{1'b0}}};
                        ui_r <= ui_r + 3'h1;
                        dqs_r <= ~dqs_r;
                    end
                end
                default: st_r <= tpr_pkg::TPR_TX_IDLE;
            endcase
        end
    end

    assign dq_o = cur_r[8*DQ_W-1 -: DQ_W];
    assign dq_oe = (st_r == tpr_pkg::TPR_TX_SEND);
    assign dqs_oe = (st_r == tpr_pkg::TPR_TX_SEND);
    assign dqs_t_o = dqs_r;
    assign dqs_c_o = ~dqs_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge dev_clk); endclocking
    default disable iff (rst_s2 || !ce_s2);

    chk_strobe_with_data: assert property (dq_oe |-> dqs_oe && (dqs_t_o != dqs_c_o))
        else $error("strobe not driven with data");
    chk_no_gap: assert property (dq_oe && last_ui && nxt_v_r |=> dq_oe && ui_r == 3'h0)
        else $error("idle cycle between streamed bursts");
    chk_burst_len: assert property ($rose(dq_oe) |-> dq_oe [*8])
        else $error("burst shorter than eight intervals");
    chk_strobe_phase: assert property ($rose(dq_oe) |-> dqs_t_o ##1 !dqs_t_o)
        else $error("strobe phase wrong at burst start");
endmodule

// ### verilog/tpr_top.sv
// Purpose: Training pattern locations, mode decode and read burst formatting
// Assumes: Commands come from logic on ref_clk; dev_clk is the device link clock
// Notes: Read-only page contents are supplied by neighbouring logic on ro_pages
`timescale 1ns/1ps
module tpr_top #(
    parameter int DQ_W = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic dev_clk,
    input wire logic cmd_valid,
    input wire tpr_pkg::tpr_op_e cmd_op,
    input wire logic [1:0] cmd_ba,
    input wire logic [12:0] cmd_addr,
    output logic cmd_ready,
    input wire logic [95:0] ro_pages,
    output logic pattern_mode,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe,
    output logic dqs_t_o,
    output logic dqs_c_o,
    output logic dqs_oe
);
    localparam int BW = tpr_pkg::BURST_UI * DQ_W;

    logic [12:0] tmr_r;
    logic [7:0] loc_r [tpr_pkg::LOC_N];
    logic [BW-1:0] slot_word_r;
    logic req_r, busy_r, ack_s1, ack_s2, ack_s3;
    logic acc, wr_acc, rd_acc, ack_seen;
    logic [1:0] page, fmt;
    logic [31:0] page_locs;
    logic [7:0] sel_loc;

    tpr_link_if #(.DQ_W(DQ_W)) lk ();

    // ----------------------------------------------------------------
    // Burst formatting
    // ----------------------------------------------------------------
    // Reserved format code falls back to serial; the controller must not use it
    function automatic logic [BW-1:0] fmt_burst(input logic [1:0] f, input logic [1:0] ba,
                                                 input logic [31:0] locs);
        logic [BW-1:0] w;
        int li;
        logic [7:0] sel;
        w = '0;
        sel = locs[int'(ba)*8 +: 8];
        for (int ui = 0; ui < tpr_pkg::BURST_UI; ui++) begin
            for (int lane = 0; lane < DQ_W; lane++) begin
                case (f)
                    tpr_pkg::FMT_PARALLEL: begin
                        w[(7-ui)*DQ_W+lane] = sel[7-(lane%8)];
                    end
                    tpr_pkg::FMT_STAGGER: begin
                        li = (int'(ba) + lane % tpr_pkg::NIBBLE) % tpr_pkg::LOC_N;
                        w[(7-ui)*DQ_W+lane] = locs[li*8 + 7 - ui];
                    end
                    default: begin
                        w[(7-ui)*DQ_W+lane] = sel[7-ui];
                    end
                endcase
            end
        end
        return w;
    endfunction

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    assign page = tmr_r[tpr_pkg::TMR_PAGE_LSB +: 2];
    assign fmt = tmr_r[tpr_pkg::TMR_FMT_LSB +: 2];
    assign pattern_mode = tmr_r[tpr_pkg::TMR_MODE_BIT];
    assign cmd_ready = ~busy_r;
    assign acc = cmd_valid && cmd_ready && ce;
    assign wr_acc = acc && pattern_mode && (cmd_op == tpr_pkg::TPR_OP_WRITE);
    assign rd_acc = acc && pattern_mode && (cmd_op == tpr_pkg::TPR_OP_READ);
    assign ack_seen = ack_s2 ^ ack_s3;

    always_comb begin
        if (page == 2'h0) begin
            page_locs = {loc_r[3], loc_r[2], loc_r[1], loc_r[0]};
        end else begin
            page_locs = ro_pages[(int'(page)-1)*32 +: 32];
        end
        sel_loc = page_locs[int'(cmd_ba)*8 +: 8];
    end

    // ----------------------------------------------------------------
    // Training mode register, written by the mode-set command only
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tmr_r <= tpr_pkg::TMR_RST;
        end else if (acc && cmd_op == tpr_pkg::TPR_OP_MODE_SET) begin
            tmr_r <= cmd_addr;
        end
    end

    // ----------------------------------------------------------------
    // Page 0 locations
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            loc_r[0] <= tpr_pkg::LOC0_RST;
            loc_r[1] <= tpr_pkg::LOC1_RST;
            loc_r[2] <= tpr_pkg::LOC2_RST;
            loc_r[3] <= tpr_pkg::LOC3_RST;
        end else if (wr_acc && page == 2'h0) begin
            // Pages 1..3 fall through untouched, a write there is dropped
            loc_r[cmd_ba] <= cmd_addr[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Burst handoff to the link domain
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else if (ce) begin
            ack_s1 <= lk.ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    // Word stays put while busy, so the link side may sample it any time
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            slot_word_r <= '0;
            req_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (ce) begin
            if (rd_acc) begin
                slot_word_r <= fmt_burst(fmt, cmd_ba, page_locs);
                req_r <= ~req_r;
                busy_r <= 1'b1;
            end else if (ack_seen) begin
                busy_r <= 1'b0;
            end
        end
    end
    assign lk.word = slot_word_r;
    assign lk.req_tgl = req_r;

    tpr_burst_tx #(.DQ_W(DQ_W)) u_tx (
        .dev_clk(dev_clk),
        .srst(srst),
        .ce(ce),
        .lk(lk.link),
        .dq_o(dq_o),
        .dq_oe(dq_oe),
        .dqs_t_o(dqs_t_o),
        .dqs_c_o(dqs_c_o),
        .dqs_oe(dqs_oe)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    logic [7:0] chk_lane1_loc;
    assign chk_lane1_loc = page_locs[((int'(cmd_ba)+1)%4)*8 +: 8];

    chk_reset_dflt: assert property ($fell(srst) |-> loc_r[0] == tpr_pkg::LOC0_RST
        && loc_r[1] == tpr_pkg::LOC1_RST && loc_r[2] == tpr_pkg::LOC2_RST
        && loc_r[3] == tpr_pkg::LOC3_RST)
        else $error("page 0 defaults wrong after reset");
    chk_write_store: assert property (wr_acc && page == 2'h0 |=> loc_r[$past(cmd_ba)]
        == $past(cmd_addr[7:0]))
        else $error("pattern write not stored");
    chk_ro_ignore: assert property (wr_acc && page != 2'h0 |=> $stable(loc_r[0])
        && $stable(loc_r[1]) && $stable(loc_r[2]) && $stable(loc_r[3]))
        else $error("write to read-only page changed storage");
    chk_hold_loc: assert property (!wr_acc |=> $stable(loc_r[0]) && $stable(loc_r[1])
        && $stable(loc_r[2]) && $stable(loc_r[3]))
        else $error("location changed without a write");
    chk_mode_decode: assert property (acc && cmd_op == tpr_pkg::TPR_OP_MODE_SET
        |=> pattern_mode == $past(cmd_addr[tpr_pkg::TMR_MODE_BIT]))
        else $error("pattern mode bit not taken");
    chk_serial_fmt: assert property (rd_acc && fmt == tpr_pkg::FMT_SERIAL
        |=> slot_word_r[BW-1 -: DQ_W] == {DQ_W{$past(sel_loc[7])}}
        && slot_word_r[DQ_W-1:0] == {DQ_W{$past(sel_loc[0])}})
        else $error("serial burst bit order wrong");
    chk_parallel_fmt: assert property (rd_acc && fmt == tpr_pkg::FMT_PARALLEL
        |=> slot_word_r[BW-1 -: DQ_W] == slot_word_r[DQ_W-1:0]
        && slot_word_r[BW-DQ_W] == $past(sel_loc[7]))
        else $error("parallel burst not held or misplaced");
    chk_stagger_fmt: assert property (rd_acc && fmt == tpr_pkg::FMT_STAGGER
        |=> slot_word_r[BW-DQ_W+1] == $past(chk_lane1_loc[7])
        && slot_word_r[1] == $past(chk_lane1_loc[0]))
        else $error("staggered lane rotation wrong");
    chk_normal_idle: assert property (acc && !pattern_mode |=> $stable(req_r))
        else $error("burst issued outside pattern mode");
endmodule

// ### verification/tpr_ctl_model.sv
// Purpose: Controller-side read capture, collects each eight-UI burst from the lanes
// Assumes: One unit interval per rising dev_clk edge, dq and strobes launched on that edge
// Notes: Counts strobe faults and the longest unbroken run of driven UIs
`timescale 1ns/1ps
module tpr_ctl_model #(
    parameter int DQ_W = 8
) (
    input wire logic dev_clk,
    input wire logic [DQ_W-1:0] dq,
    input wire logic dq_oe,
    input wire logic dqs_t,
    input wire logic dqs_c,
    input wire logic dqs_oe,
    output logic [7:0] bcnt,
    output logic [7:0] run_max,
    output logic [7:0] strobe_bad,
    output logic [8*DQ_W-1:0] words [0:7]
);
    logic [7:0] run;
    logic [8*DQ_W-1:0] cur;

    initial begin
        bcnt = 8'h00;
        run_max = 8'h00;
        strobe_bad = 8'h00;
        run = 8'h00;
        cur = '0;
    end

    // Samples the value launched one edge earlier; UI0 carries dqs_t high
    always @(posedge dev_clk) begin
        if (dq_oe === 1'b1) begin
            cur[int'(run[2:0])*DQ_W +: DQ_W] = dq;
            if (dqs_oe !== 1'b1 || dqs_t !== ~run[0] || dqs_c !== run[0]) begin
                strobe_bad <= strobe_bad + 8'h01;
            end
            if (run[2:0] == 3'h7) begin
                words[bcnt[2:0]] <= cur;
                bcnt <= bcnt + 8'h01;
            end
            run = run + 8'h01;
            if (run > run_max) begin
                run_max <= run;
            end
        end else begin
            run = 8'h00;
        end
    end
endmodule

// ### verification/training_pattern_readout_tb.sv
// Purpose: Command-level tests of pattern storage, paging and read return layouts
// Assumes: x8 lanes checked in full, x4 and x16 instances checked per UI against them
// Notes: Reset is held longer than six cycles so the link domain sees it
`timescale 1ns/1ps
module training_pattern_readout_tb;
    localparam logic [95:0] RO = 96'hc3b2a190_8776655a_4433221e;
    logic ref_clk;
    logic dev_clk;
    logic srst;
    logic ce;
    logic cmd_valid;
    tpr_pkg::tpr_op_e cmd_op;
    logic [1:0] cmd_ba;
    logic [12:0] cmd_addr;
    logic cmd_ready;
    logic [95:0] ro_pages;
    logic pattern_mode;
    logic [7:0] dq_o;
    logic dq_oe;
    logic dqs_t_o;
    logic dqs_c_o;
    logic dqs_oe;
    logic [7:0] bcnt;
    logic [7:0] run_max;
    logic [7:0] strobe_bad;
    logic [63:0] words [0:7];
    logic [3:0] dq4;
    logic [15:0] dq16;
    logic oe4, st4, sc4, so4, oe16, st16, sc16, so16;
    logic [7:0] sb4;
    logic [7:0] sb16;
    logic [31:0] words4 [0:7];
    logic [127:0] words16 [0:7];
    logic [7:0] loc [0:15];
    logic [1:0] cf;
    logic [1:0] cp;
    logic cm;
    logic [7:0] c;
    int bad_count = 0;
    int tests_run = 0;

    tpr_top #(.DQ_W(8)) i_tpr_top (.ref_clk(ref_clk), .srst(srst), .ce(ce), .dev_clk(dev_clk),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr),
        .cmd_ready(cmd_ready), .ro_pages(ro_pages), .pattern_mode(pattern_mode), .dq_o(dq_o),
        .dq_oe(dq_oe), .dqs_t_o(dqs_t_o), .dqs_c_o(dqs_c_o), .dqs_oe(dqs_oe));
    tpr_ctl_model #(.DQ_W(8)) i_tpr_ctl_model (.dev_clk(dev_clk), .dq(dq_o), .dq_oe(dq_oe),
        .dqs_t(dqs_t_o), .dqs_c(dqs_c_o), .dqs_oe(dqs_oe), .bcnt(bcnt), .run_max(run_max),
        .strobe_bad(strobe_bad), .words(words));
    // Narrow and wide devices share every input with the x8 one
    tpr_top #(.DQ_W(4)) i_tpr_top_x4 (.ref_clk(ref_clk), .srst(srst), .ce(ce),
        .dev_clk(dev_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ba(cmd_ba),
        .cmd_addr(cmd_addr), .cmd_ready(), .ro_pages(ro_pages), .pattern_mode(), .dq_o(dq4),
        .dq_oe(oe4), .dqs_t_o(st4), .dqs_c_o(sc4), .dqs_oe(so4));
    tpr_ctl_model #(.DQ_W(4)) i_tpr_ctl_model_x4 (.dev_clk(dev_clk), .dq(dq4), .dq_oe(oe4),
        .dqs_t(st4), .dqs_c(sc4), .dqs_oe(so4), .bcnt(), .run_max(), .strobe_bad(sb4),
        .words(words4));
    tpr_top #(.DQ_W(16)) i_tpr_top_x16 (.ref_clk(ref_clk), .srst(srst), .ce(ce),
        .dev_clk(dev_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ba(cmd_ba),
        .cmd_addr(cmd_addr), .cmd_ready(), .ro_pages(ro_pages), .pattern_mode(), .dq_o(dq16),
        .dq_oe(oe16), .dqs_t_o(st16), .dqs_c_o(sc16), .dqs_oe(so16));
    tpr_ctl_model #(.DQ_W(16)) i_tpr_ctl_model_x16 (.dev_clk(dev_clk), .dq(dq16),
        .dq_oe(oe16), .dqs_t(st16), .dqs_c(sc16), .dqs_oe(so16), .bcnt(), .run_max(),
        .strobe_bad(sb16), .words(words16));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Link clock keeps an unrelated phase to ref_clk
    initial begin
        dev_clk = 1'b0;
        #3;
        forever #16 dev_clk = ~dev_clk;
    end

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task test_done;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Request held until an edge samples cmd_ready high
    task cmd(input tpr_pkg::tpr_op_e op, input logic [1:0] ba, input logic [12:0] a);
        int n;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_ba <= ba;
        cmd_addr <= a;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 200);
        if (n >= 200) chk("cmd_ready", 64'h0, 64'h1);
        cmd_valid <= 1'b0;
    endtask

    task mode(input logic [1:0] f, input logic m, input logic [1:0] p);
        cf = f;
        cm = m;
        cp = p;
        cmd(tpr_pkg::TPR_OP_MODE_SET, 2'h0, {f, 8'h00, m, p});
    endtask

    task wr(input logic [1:0] ba, input logic [7:0] d);
        cmd(tpr_pkg::TPR_OP_WRITE, ba, {5'h1a, d});
        if (cm && cp == 2'h0) loc[{2'h0, ba}] = d;
    endtask

    // Expected burst: UI u of lane k sits at bit u*8+k
    function automatic logic [63:0] ew(input logic [1:0] ba);
        logic [63:0] w;
        logic [7:0] v;
        for (int u = 0; u < 8; u++) begin
            for (int k = 0; k < 8; k++) begin
                v = loc[{cp, (cf == 2'h2) ? ba + k[1:0] : ba}];
                w[u*8+k] = (cf == 2'h1) ? v[7-k] : v[7-u];
            end
        end
        return w;
    endfunction

    task wait_bursts(input logic [7:0] target);
        int n;
        n = 0;
        while (bcnt !== target && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 400) chk("burst wait", 64'h0, 64'h1);
    endtask

    // x4 keeps lanes 0..3 of the x8 burst, x16 repeats the x8 byte on both halves
    task wide(input logic [2:0] i, input logic [1:0] ba);
        logic [63:0] e;
        e = ew(ba);
        for (int u = 0; u < 8; u++) begin
            chk("x4 burst", {60'h0, words4[i][u*4 +: 4]}, {60'h0, e[u*8 +: 4]});
            chk("x16 burst", {48'h0, words16[i][u*16 +: 16]},
                {48'h0, {2{e[u*8 +: 8]}}});
        end
    endtask

    task rd(input logic [1:0] ba);
        c = bcnt;
        cmd(tpr_pkg::TPR_OP_READ, ba, 13'h0000);
        wait_bursts(c + 8'h01);
        chk("burst", words[c[2:0]], ew(ba));
        wide(c[2:0], ba);
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = tpr_pkg::TPR_OP_NOP;
        cmd_ba = 2'h0;
        cmd_addr = 13'h0000;
        ro_pages = RO;
        cf = 2'h0;
        cp = 2'h0;
        cm = 1'b0;
        loc[0] = 8'h55;
        loc[1] = 8'h33;
        loc[2] = 8'h0f;
        loc[3] = 8'h00;
        for (int i = 0; i < 12; i++) loc[4+i] = RO[i*8 +: 8];
        repeat (14) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (20) @(posedge ref_clk);

        chk("pattern_mode", pattern_mode, 1'b0);
        c = bcnt;
        cmd(tpr_pkg::TPR_OP_READ, 2'h0, 13'h0000);
        wr(2'h0, 8'hff);
        repeat (60) @(posedge ref_clk);
        chk("bcnt", bcnt, c);
        ce <= 1'b0;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= tpr_pkg::TPR_OP_MODE_SET;
        cmd_addr <= 13'h0004;
        repeat (2) @(posedge ref_clk);
        cmd_valid <= 1'b0;
        ce <= 1'b1;
        @(posedge ref_clk);
        chk("pattern_mode", pattern_mode, 1'b0);
        $display("Test normal mode done");

        mode(2'h0, 1'b1, 2'h0);
        @(posedge ref_clk);
        chk("pattern_mode", pattern_mode, 1'b1);
        for (int b = 0; b < 4; b++) rd(b[1:0]);
        $display("Test defaults done");

        wr(2'h1, 8'ha6);
        rd(2'h1);
        for (int p = 1; p < 4; p++) begin
            mode(2'h0, 1'b1, p[1:0]);
            wr(p[1:0], 8'h11);
            rd(p[1:0]);
        end
        mode(2'h0, 1'b1, 2'h0);
        rd(2'h1);
        $display("Test paging done");

        // Parallel and staggered reads stay on page 0, no reserved code used
        mode(2'h1, 1'b1, 2'h0);
        for (int b = 0; b < 4; b++) rd(b[1:0]);
        $display("Test parallel done");

        mode(2'h2, 1'b1, 2'h0);
        c = bcnt;
        for (int b = 0; b < 4; b++) cmd(tpr_pkg::TPR_OP_READ, b[1:0], 13'h0000);
        wait_bursts(c + 8'h04);
        for (int b = 0; b < 4; b++) begin
            chk("stagger", words[c[2:0]+b[2:0]], ew(b[1:0]));
            wide(c[2:0]+b[2:0], b[1:0]);
        end
        chk("run_max", run_max, 8'h20);
        chk("strobe_bad", strobe_bad, 8'h00);
        chk("strobe_bad x4", sb4, 8'h00);
        chk("strobe_bad x16", sb16, 8'h00);
        $display("Test staggered stream done");
        test_done();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        test_done();
    end
endmodule
